// File: hdl/tma_regs.vh
`ifndef TMA_REGS_VH
`define TMA_REGS_VH

`define TMA_VEC_INSTR_MISS_ADDR     16'h1000
`define TMA_VEC_DLOAD     16'h1100
`define TMA_VEC_DSTORE    16'h1200
`define TMA_VEC_RESET     16'h0000

`define TMA_KIND_INSTR    2'h0
`define TMA_KIND_LOAD     2'h1
`define TMA_KIND_STORE    2'h2

`define TMA_SPR_INSTR_MISS_ADDR     4'h0
`define TMA_SPR_INSTR_MATCH_WORD      4'h1
`define TMA_SPR_DATA_MISS_ADDR     4'h2
`define TMA_SPR_DATA_MATCH_WORD      4'h3
`define TMA_SPR_PRIMARY_GROUP_ADDR     4'h4
`define TMA_SPR_SECONDARY_GROUP_ADDR     4'h5
`define TMA_SPR_PAGE      4'h6
`define TMA_SPR_SRR       4'h7
`define TMA_SPR_MSR       4'h8
`define TMA_SPR_TBASE     4'h9

// bit n of the big-endian numbering sits at [31-n]
`define TMA_SRR_CRF_HI    31
`define TMA_SRR_CRF_LO    28
`define TMA_SRR_KEY       19
`define TMA_SRR_DI        18
`define TMA_SRR_WAY       17
`define TMA_SRR_SL        16
`define TMA_MSR_SCRATCH_BANK_SELECT      17
`define TMA_MSR_PR        14
`define TMA_MSR_IR        5
`define TMA_MSR_DR        4
`define TMA_MSR_RESET     32'h00000000
`define TMA_SRR_RESET     32'h00000000
`define TMA_REG_RESET     32'h00000000

`define TMA_MATCH_V       31
`define TMA_MATCH_H       6
`define TMA_PAGE_R        8
`define TMA_PAGE_C        7
`define TMA_ORG_HI        31
`define TMA_ORG_LO        25
`define TMA_IDX_HI        16
`define TMA_IDX_LO        12
`define TMA_API_HI        27
`define TMA_API_LO        22

`endif

// File: hdl/tma_hash.v
`timescale 1ns/100ps
module tma_hash
(
    input  wire [23:0] segment_id_field_i,
    input  wire [15:0] pidx_i,
    output wire [18:0] prim_o,
    output wire [18:0] sec_o
);
    // primary hash is segment id xor page index, secondary its complement
    assign prim_o = segment_id_field_i[18:0] ^ {3'b000, pidx_i};
    assign sec_o  = ~prim_o;
endmodule

// File: hdl/tma_tlb.v
`timescale 1ns/100ps
`include "tma_regs.vh"
module tma_tlb
#(
    parameter IDXW = 5
)
(
    input  wire            mclk_i,
    input  wire            rstn_i,
    input  wire [IDXW-1:0] rd_idx_i,
    output wire [31:0]     m0_o,
    output wire [31:0]     m1_o,
    output wire [31:0]     p0_o,
    output wire [31:0]     p1_o,
    output wire            v0_o,
    output wire            v1_o,
    output wire            lru_o,
    input  wire            touch_i,
    input  wire            touch_way_i,
    input  wire            we_i,
    input  wire [IDXW-1:0] wr_idx_i,
    input  wire            wr_way_i,
    input  wire [31:0]     wr_m_i,
    input  wire [31:0]     wr_p_i
);
    localparam SETS = 1 << IDXW;
    reg [31:0]     mw0 [0:SETS-1];
    reg [31:0]     mw1 [0:SETS-1];
    reg [31:0]     pw0 [0:SETS-1];
    reg [31:0]     pw1 [0:SETS-1];
    reg [SETS-1:0] val0;
    reg [SETS-1:0] val1;
    reg [SETS-1:0] lru;

    assign m0_o  = mw0[rd_idx_i];
    assign m1_o  = mw1[rd_idx_i];
    assign p0_o  = pw0[rd_idx_i];
    assign p1_o  = pw1[rd_idx_i];
    assign v0_o  = val0[rd_idx_i];
    assign v1_o  = val1[rd_idx_i];
    assign lru_o = lru[rd_idx_i];

    always @(posedge mclk_i)
    begin
        if (we_i && !wr_way_i)
        begin
            mw0[wr_idx_i] <= wr_m_i;
            pw0[wr_idx_i] <= wr_p_i;
        end
        if (we_i && wr_way_i)
        begin
            mw1[wr_idx_i] <= wr_m_i;
            pw1[wr_idx_i] <= wr_p_i;
        end
    end

    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            val0 <= {SETS{1'b0}};
            val1 <= {SETS{1'b0}};
            lru  <= {SETS{1'b0}};
        end
        else if (we_i)
        begin
            if (wr_way_i)
                val1[wr_idx_i] <= wr_m_i[`TMA_MATCH_V];
            else
                val0[wr_idx_i] <= wr_m_i[`TMA_MATCH_V];
            lru[wr_idx_i] <= ~wr_way_i;
        end
        else if (touch_i)
        begin
            lru[rd_idx_i] <= ~touch_way_i;
        end
    end
endmodule

// File: hdl/tma_assist.v
`timescale 1ns/100ps
`include "tma_regs.vh"
module tma_assist
(
    input  wire        mclk_i,
    input  wire        rstn_i,
    input  wire        lk_valid_i,
    input  wire [1:0]  lk_kind_i,
    input  wire [31:0] lk_ea_i,
    input  wire [23:0] seg_segment_id_field_i,
    input  wire        seg_super_key_i,
    input  wire        seg_user_key_i,
    input  wire [3:0]  cond_field_zero_i,
    input  wire        exc_req_i,
    input  wire        rfi_i,
    input  wire        ld_instr_i,
    input  wire        ld_data_i,
    input  wire [31:0] ld_ea_i,
    input  wire        spr_rd_i,
    input  wire        spr_wr_i,
    input  wire [3:0]  spr_sel_i,
    input  wire [31:0] spr_wdata_i,
    input  wire [4:0]  gpr_num_i,
    output reg         hit_o,
    output reg  [31:0] page_o,
    output reg         miss_o,
    output reg  [15:0] vector_o,
    output reg         spr_ack_o,
    output reg         spr_err_o,
    output reg  [31:0] spr_rdata_o,
    output reg         gpr_temp_o,
    output wire        scratch_bank_o,
    output wire        fetch_xlate_on_o,
    output wire        data_xlate_on_o,
    output wire        user_mode_o
);
    reg  [31:0] machine_state_reg;
    reg  [31:0] srr;
    reg  [31:0] instr_miss_addr;
    reg  [31:0] data_miss_addr;
    reg  [31:0] instr_match_word;
    reg  [31:0] data_match_word;
    reg  [31:0] primary_group_addr;
    reg  [31:0] secondary_group_addr;
    reg  [31:0] phys_page_word;
    reg  [31:0] table_base;

    wire [31:0] im0;
    wire [31:0] im1;
    wire [31:0] ip0;
    wire [31:0] ip1;
    wire        iv0;
    wire        iv1;
    wire        ilru;
    wire [31:0] dm0;
    wire [31:0] dm1;
    wire [31:0] dp0;
    wire [31:0] dp1;
    wire        dv0;
    wire        dv1;
    wire        dlru;
    wire [18:0] hprim;
    wire [18:0] hsec;

    assign scratch_bank_o   = machine_state_reg[`TMA_MSR_SCRATCH_BANK_SELECT];
    assign fetch_xlate_on_o = machine_state_reg[`TMA_MSR_IR];
    assign data_xlate_on_o  = machine_state_reg[`TMA_MSR_DR];
    assign user_mode_o      = machine_state_reg[`TMA_MSR_PR];

    // lookup against the buffer chosen by the access kind
    wire        is_instr;
    wire        is_load;
    wire        is_store;
    wire [31:0] want;
    wire [31:0] m0;
    wire [31:0] m1;
    wire [31:0] p0;
    wire [31:0] p1;
    wire        hit0;
    wire        hit1;
    wire        hit;
    wire [31:0] hpage;
    wire        clean;
    wire        miss;
    wire        good;
    wire        lru_way;
    wire        key;
    wire [31:0] grp1;
    wire [31:0] grp2;
    wire        priv_bad;
    wire        ld_way;
    wire        spr_any;
    wire        spr_ok;
    wire        wr_page;
    wire        wr_tbase;
    wire        wr_srr;
    wire        wr_msr;
    wire        temp_num;

    assign is_instr = (lk_kind_i == `TMA_KIND_INSTR);
    assign is_load  = (lk_kind_i == `TMA_KIND_LOAD);
    assign is_store = (lk_kind_i == `TMA_KIND_STORE);
    assign want     = {1'b1, seg_segment_id_field_i, 1'b0, lk_ea_i[`TMA_API_HI:`TMA_API_LO]};
    assign m0       = is_instr ? im0 : dm0;
    assign m1       = is_instr ? im1 : dm1;
    assign p0       = is_instr ? ip0 : dp0;
    assign p1       = is_instr ? ip1 : dp1;
    assign hit0     = (is_instr ? iv0 : dv0) && (m0 == want);
    assign hit1     = (is_instr ? iv1 : dv1) && (m1 == want);
    assign hit      = hit0 | hit1;
    assign hpage    = hit0 ? p0 : p1;
    assign clean    = is_store && hit && !hpage[`TMA_PAGE_C];
    assign miss     = lk_valid_i && (!hit || clean);
    assign good     = lk_valid_i && hit && !clean;
    assign lru_way  = is_instr ? ilru : dlru;
    assign key      = machine_state_reg[`TMA_MSR_PR] ? seg_user_key_i : seg_super_key_i;
    assign grp1     = {table_base[`TMA_ORG_HI:`TMA_ORG_LO], hprim, 6'h00};
    assign grp2     = {table_base[`TMA_ORG_HI:`TMA_ORG_LO], hsec, 6'h00};
    assign priv_bad = machine_state_reg[`TMA_MSR_PR];
    assign ld_way   = srr[`TMA_SRR_WAY];
    // register writes are dropped in user mode
    assign spr_any  = spr_rd_i | spr_wr_i;
    assign spr_ok   = spr_wr_i && !priv_bad;
    assign wr_page  = spr_ok && (spr_sel_i == `TMA_SPR_PAGE);
    assign wr_tbase = spr_ok && (spr_sel_i == `TMA_SPR_TBASE);
    assign wr_srr   = spr_ok && (spr_sel_i == `TMA_SPR_SRR);
    assign wr_msr   = spr_ok && (spr_sel_i == `TMA_SPR_MSR);
    assign temp_num = (gpr_num_i < 5'h04);

    reg  [31:0] next_srr;
    reg  [15:0] next_vec;

    always @*
    begin
        next_srr = {16'h0000, machine_state_reg[15:0]};
        next_vec = `TMA_VEC_DSTORE;
        if (miss)
        begin
            next_srr[`TMA_SRR_CRF_HI:`TMA_SRR_CRF_LO] = cond_field_zero_i;
            next_srr[`TMA_SRR_KEY] = key;
            next_srr[`TMA_SRR_DI]  = is_instr;
            next_srr[`TMA_SRR_WAY] = lru_way;
            next_srr[`TMA_SRR_SL]  = is_load;
            case (lk_kind_i)
                `TMA_KIND_INSTR: next_vec = `TMA_VEC_INSTR_MISS_ADDR;
                `TMA_KIND_LOAD:  next_vec = `TMA_VEC_DLOAD;
                default:         next_vec = `TMA_VEC_DSTORE;
            endcase
        end
    end

    tma_hash u_hash
    (
        .segment_id_field_i (seg_segment_id_field_i),
        .pidx_i (lk_ea_i[27:12]),
        .prim_o (hprim),
        .sec_o  (hsec)
    );

    tma_tlb #(.IDXW(5)) u_instr_translation_buffer
    (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .rd_idx_i    (lk_ea_i[`TMA_IDX_HI:`TMA_IDX_LO]),
        .m0_o        (im0),
        .m1_o        (im1),
        .p0_o        (ip0),
        .p1_o        (ip1),
        .v0_o        (iv0),
        .v1_o        (iv1),
        .lru_o       (ilru),
        .touch_i     (good && is_instr),
        .touch_way_i (hit1),
        .we_i        (ld_instr_i),
        .wr_idx_i    (ld_ea_i[`TMA_IDX_HI:`TMA_IDX_LO]),
        .wr_way_i    (ld_way),
        .wr_m_i      (instr_match_word),
        .wr_p_i      (phys_page_word)
    );

    tma_tlb #(.IDXW(5)) u_data_translation_buffer
    (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .rd_idx_i    (lk_ea_i[`TMA_IDX_HI:`TMA_IDX_LO]),
        .m0_o        (dm0),
        .m1_o        (dm1),
        .p0_o        (dp0),
        .p1_o        (dp1),
        .v0_o        (dv0),
        .v1_o        (dv1),
        .lru_o       (dlru),
        .touch_i     (good && !is_instr),
        .touch_way_i (hit1),
        .we_i        (ld_data_i),
        .wr_idx_i    (ld_ea_i[`TMA_IDX_HI:`TMA_IDX_LO]),
        .wr_way_i    (ld_way),
        .wr_m_i      (data_match_word),
        .wr_p_i      (phys_page_word)
    );

    // lookup answer, one cycle after the request
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hit_o    <= 1'b0;
            page_o   <= `TMA_REG_RESET;
            miss_o   <= 1'b0;
            vector_o <= `TMA_VEC_RESET;
        end
        else
        begin
            hit_o  <= good;
            page_o <= good ? hpage : `TMA_REG_RESET;
            miss_o <= miss;
            if (miss)
                vector_o <= next_vec;
        end
    end

    // captured miss state
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            instr_miss_addr      <= `TMA_REG_RESET;
            data_miss_addr       <= `TMA_REG_RESET;
            instr_match_word     <= `TMA_REG_RESET;
            data_match_word      <= `TMA_REG_RESET;
            primary_group_addr   <= `TMA_REG_RESET;
            secondary_group_addr <= `TMA_REG_RESET;
        end
        else if (miss)
        begin
            if (is_instr)
            begin
                instr_miss_addr  <= lk_ea_i;
                instr_match_word <= want;
            end
            else
            begin
                data_miss_addr  <= lk_ea_i;
                data_match_word <= want;
            end
            primary_group_addr   <= grp1;
            secondary_group_addr <= grp2;
        end
    end

    // machine state and saved status
    // miss outranks an exception, which outranks return and register writes
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            machine_state_reg <= `TMA_MSR_RESET;
            srr <= `TMA_SRR_RESET;
        end
        else if (miss)
        begin
            srr <= next_srr;
            machine_state_reg[`TMA_MSR_SCRATCH_BANK_SELECT] <= 1'b1;
            machine_state_reg[`TMA_MSR_IR]   <= 1'b0;
            machine_state_reg[`TMA_MSR_DR]   <= 1'b0;
            machine_state_reg[`TMA_MSR_PR]   <= 1'b0;
        end
        else if (exc_req_i)
        begin
            srr <= next_srr;
            machine_state_reg[`TMA_MSR_IR] <= 1'b0;
            machine_state_reg[`TMA_MSR_DR] <= 1'b0;
            machine_state_reg[`TMA_MSR_PR] <= 1'b0;
        end
        else if (rfi_i)
        begin
            // return clears scratch select and reloads bits 15:0 from the saved word
            machine_state_reg <= {machine_state_reg[31:18], 1'b0, machine_state_reg[16], srr[15:0]};
        end
        else
        begin
            if (wr_srr)
                srr <= spr_wdata_i;
            if (wr_msr)
                machine_state_reg <= spr_wdata_i;
        end
    end

    // software-written registers
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            phys_page_word <= `TMA_REG_RESET;
            table_base     <= `TMA_REG_RESET;
        end
        else
        begin
            if (wr_page)
                phys_page_word <= spr_wdata_i;
            if (wr_tbase)
                table_base <= spr_wdata_i;
        end
    end

    reg [31:0] rd_mux;

    always @*
    begin
        case (spr_sel_i)
            `TMA_SPR_INSTR_MISS_ADDR: rd_mux = instr_miss_addr;
            `TMA_SPR_INSTR_MATCH_WORD:  rd_mux = instr_match_word;
            `TMA_SPR_DATA_MISS_ADDR: rd_mux = data_miss_addr;
            `TMA_SPR_DATA_MATCH_WORD:  rd_mux = data_match_word;
            `TMA_SPR_PRIMARY_GROUP_ADDR: rd_mux = primary_group_addr;
            `TMA_SPR_SECONDARY_GROUP_ADDR: rd_mux = secondary_group_addr;
            `TMA_SPR_PAGE:  rd_mux = phys_page_word;
            `TMA_SPR_SRR:   rd_mux = srr;
            `TMA_SPR_MSR:   rd_mux = machine_state_reg;
            `TMA_SPR_TBASE: rd_mux = table_base;
            default:        rd_mux = `TMA_REG_RESET;
        endcase
    end

    // register access answer and scratch remap, one cycle late
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            spr_ack_o   <= 1'b0;
            spr_err_o   <= 1'b0;
            spr_rdata_o <= `TMA_REG_RESET;
            gpr_temp_o  <= 1'b0;
        end
        else
        begin
            spr_ack_o   <= spr_any;
            spr_err_o   <= spr_any && priv_bad;
            spr_rdata_o <= (spr_rd_i && !priv_bad) ? rd_mux : `TMA_REG_RESET;
            gpr_temp_o  <= machine_state_reg[`TMA_MSR_SCRATCH_BANK_SELECT] && temp_num;
        end
    end
endmodule

// File: testbench/tma_assist_properties.sv
`timescale 1ns/100ps
module tma_chk
(
    input wire        mclk_i,
    input wire        rstn_i,
    input wire        lk_valid_i,
    input wire [1:0]  lk_kind_i,
    input wire        exc_req_i,
    input wire        rfi_i,
    input wire        spr_rd_i,
    input wire        spr_wr_i,
    input wire [4:0]  gpr_num_i,
    input wire        hit_o,
    input wire        miss_o,
    input wire [15:0] vector_o,
    input wire        spr_ack_o,
    input wire        spr_err_o,
    input wire [31:0] spr_rdata_o,
    input wire        gpr_temp_o,
    input wire        scratch_bank_o,
    input wire        fetch_xlate_on_o,
    input wire        data_xlate_on_o,
    input wire        user_mode_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_instr_miss_addr;
        lk_valid_i && lk_kind_i == 2'h0 ##1 miss_o;
    endsequence
    sequence s_lmiss;
        lk_valid_i && lk_kind_i == 2'h1 ##1 miss_o;
    endsequence
    sequence s_smiss;
        lk_valid_i && lk_kind_i == 2'h2 ##1 miss_o;
    endsequence
    property p_vec_i;
        s_instr_miss_addr |-> vector_o == 16'h1000;
    endproperty
    property p_vec_l;
        s_lmiss |-> vector_o == 16'h1100;
    endproperty
    property p_vec_s;
        s_smiss |-> vector_o == 16'h1200;
    endproperty
    property p_one;
        lk_valid_i |=> hit_o != miss_o;
    endproperty
    property p_miss_st;
        miss_o |-> scratch_bank_o && !fetch_xlate_on_o && !data_xlate_on_o && !user_mode_o;
    endproperty
    property p_exc;
        exc_req_i |=> !fetch_xlate_on_o && !data_xlate_on_o;
    endproperty
    property p_rfi;
        rfi_i && !lk_valid_i && !exc_req_i |=> !scratch_bank_o;
    endproperty
    property p_priv;
        (spr_rd_i || spr_wr_i) && user_mode_o |=> spr_err_o && spr_rdata_o == 32'h00000000;
    endproperty
    property p_sup;
        (spr_rd_i || spr_wr_i) && !user_mode_o |=> spr_ack_o && !spr_err_o;
    endproperty
    property p_gpr;
        gpr_temp_o == $past(scratch_bank_o && (gpr_num_i < 5'h04));
    endproperty
    a_vec_i: assert property (p_vec_i) else $error("instr miss vector");
    a_vec_l: assert property (p_vec_l) else $error("load miss vector");
    a_vec_s: assert property (p_vec_s) else $error("store miss vector");
    a_one: assert property (p_one) else $error("lookup answer");
    a_miss_st: assert property (p_miss_st) else $error("miss state");
    a_exc: assert property (p_exc) else $error("exception enables");
    a_rfi: assert property (p_rfi) else $error("return bank");
    a_priv: assert property (p_priv) else $error("user access");
    a_sup: assert property (p_sup) else $error("supervisor access");
    a_gpr: assert property (p_gpr) else $error("temp bank map");
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/100ps
`include "tma_regs.vh"
module tb_top;
    reg         mclk_i = 1'b0;
    reg         rstn_i = 1'b0;
    reg         lk_valid_i = 1'b0, exc_req_i = 1'b0, rfi_i = 1'b0;
    reg         ld_instr_i = 1'b0, ld_data_i = 1'b0, spr_rd_i = 1'b0, spr_wr_i = 1'b0;
    reg         seg_super_key_i = 1'b1, seg_user_key_i = 1'b0;
    reg  [1:0]  lk_kind_i = 2'h0;
    reg  [31:0] lk_ea_i = 32'h0, ld_ea_i = 32'h0, spr_wdata_i = 32'h0;
    reg  [23:0] seg_segment_id_field_i = 24'h0;
    reg  [3:0]  cond_field_zero_i = 4'h0, spr_sel_i = 4'h0;
    reg  [4:0]  gpr_num_i = 5'h0;
    wire        hit_o, miss_o, spr_ack_o, spr_err_o, gpr_temp_o;
    wire        scratch_bank_o, fetch_xlate_on_o, data_xlate_on_o, user_mode_o;
    wire [31:0] page_o, spr_rdata_o;
    wire [15:0] vector_o;
    reg  [31:0] exq[$];
    integer     err_total = 0, total_checks = 0;
    reg  [31:0] ea, e0, tb, pw;
    reg  [23:0] vs;
    reg  [18:0] hs;
    reg  [3:0]  cf;
    tma_assist uut (.mclk_i, .rstn_i, .lk_valid_i, .lk_kind_i, .lk_ea_i, .seg_segment_id_field_i,
        .seg_super_key_i, .seg_user_key_i, .cond_field_zero_i, .exc_req_i, .rfi_i,
        .ld_instr_i, .ld_data_i, .ld_ea_i, .spr_rd_i, .spr_wr_i, .spr_sel_i, .spr_wdata_i,
        .gpr_num_i, .hit_o, .page_o, .miss_o, .vector_o, .spr_ack_o, .spr_err_o,
        .spr_rdata_o, .gpr_temp_o, .scratch_bank_o, .fetch_xlate_on_o, .data_xlate_on_o,
        .user_mode_o);
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) #1 gpr_num_i = 5'($urandom_range(7, 0));
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp)
            begin
                err_total = err_total + 1;
                $display("mismatch result exp %h seen %h", exp, seen);
            end
        end
    endtask
    task results;
        begin
            if (err_total == 0 && total_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task tick;
        begin
            @(posedge mclk_i);
            #1;
        end
    endtask
    task look(input [1:0] k, input [31:0] a, input [31:0] e);
        begin
            lk_kind_i = k;
            lk_ea_i = a;
            lk_valid_i = 1'b1;
            exq.push_back(e);
            tick;
            lk_valid_i = 1'b0;
        end
    endtask
    task spr(input w, input [3:0] s, input [31:0] d, input [31:0] e);
        begin
            spr_sel_i = s;
            spr_wdata_i = d;
            spr_wr_i = w;
            spr_rd_i = !w;
            exq.push_back(e);
            tick;
            spr_wr_i = 1'b0;
            spr_rd_i = 1'b0;
            tick;
        end
    endtask
    task pl(input [3:0] p);
        begin
            {exc_req_i, rfi_i, ld_instr_i, ld_data_i} = p;
            tick;
            {exc_req_i, rfi_i, ld_instr_i, ld_data_i} = 4'h0;
        end
    endtask
    always @(negedge mclk_i)
        if (rstn_i && (spr_ack_o === 1'b1 || spr_err_o === 1'b1 || miss_o === 1'b1 || hit_o === 1'b1))
        begin
            if (exq.size() == 0)
                chk(32'hFFFFFFFF, 32'h00000000);
            else
                chk(spr_ack_o | spr_err_o ? spr_rdata_o : miss_o ? {16'h0000, vector_o} : page_o,
                    exq.pop_front());
        end
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        chk(32'h0, 32'h1);
        results;
    end
    initial
    begin
        void'($urandom(78318));
        repeat (3) @(posedge mclk_i);
        #1;
        rstn_i = 1'b1;
        spr(0, `TMA_SPR_MSR, 0, `TMA_MSR_RESET);
        spr(0, `TMA_SPR_SRR, 0, `TMA_SRR_RESET);
        ea = $urandom;
        e0 = ea;
        vs = 24'($urandom);
        cf = 4'($urandom);
        tb = $urandom;
        seg_segment_id_field_i = vs;
        cond_field_zero_i = cf;
        hs = vs[18:0] ^ {3'h0, ea[27:12]};
        spr(1, `TMA_SPR_TBASE, tb, 0);
        look(`TMA_KIND_INSTR, ea, `TMA_VEC_INSTR_MISS_ADDR);
        spr(0, `TMA_SPR_INSTR_MISS_ADDR, 0, ea);
        spr(0, `TMA_SPR_INSTR_MATCH_WORD, 0, {1'b1, vs, 1'b0, ea[27:22]});
        spr(0, `TMA_SPR_PRIMARY_GROUP_ADDR, 0, {tb[31:25], hs, 6'h00});
        spr(0, `TMA_SPR_SECONDARY_GROUP_ADDR, 0, {tb[31:25], ~hs, 6'h00});
        spr(0, `TMA_SPR_SRR, 0, {cf, 8'h00, 4'hC, 16'h0000});
        cond_field_zero_i = ~cf;
        pw = $urandom | 32'h00000080;
        spr(1, `TMA_SPR_PAGE, pw, 0);
        ld_ea_i = ea;
        pl(4'h2);
        look(`TMA_KIND_INSTR, ea, pw);
        cond_field_zero_i = cf;
        pl(4'h4);
        spr(0, `TMA_SPR_MSR, 0, 32'h00000000);
        ea = $urandom;
        hs = vs[18:0] ^ {3'h0, ea[27:12]};
        look(`TMA_KIND_LOAD, ea, `TMA_VEC_DLOAD);
        spr(0, `TMA_SPR_DATA_MISS_ADDR, 0, ea);
        spr(0, `TMA_SPR_DATA_MATCH_WORD, 0, {1'b1, vs, 1'b0, ea[27:22]});
        spr(0, `TMA_SPR_PRIMARY_GROUP_ADDR, 0, {tb[31:25], hs, 6'h00});
        spr(0, `TMA_SPR_SRR, 0, {cf, 8'h00, 4'h9, 16'h0000});
        spr(1, `TMA_SPR_SRR, {cf, 8'h00, 4'hB, 16'h0000}, 0);
        pw = $urandom & 32'hFFFFFF7F;
        spr(1, `TMA_SPR_PAGE, pw, 0);
        ld_ea_i = ea;
        pl(4'h1);
        look(`TMA_KIND_STORE, ea, `TMA_VEC_DSTORE);
        spr(0, `TMA_SPR_SRR, 0, {cf, 8'h00, 4'h8, 16'h0000});
        look(`TMA_KIND_LOAD, ea, pw);
        spr(1, `TMA_SPR_MSR, 32'h00004020, 0);
        spr(0, `TMA_SPR_INSTR_MISS_ADDR, 0, 0);
        seg_super_key_i = 1'b0;
        seg_user_key_i = 1'b1;
        ea = e0 ^ 32'h0FC00000;
        look(`TMA_KIND_INSTR, ea, `TMA_VEC_INSTR_MISS_ADDR);
        spr(0, `TMA_SPR_SRR, 0, {cf, 8'h00, 4'hE, 16'h4020});
        spr(0, `TMA_SPR_MSR, 0, 32'h00020000);
        spr(1, `TMA_SPR_MSR, 32'h00004010, 0);
        pl(4'h8);
        spr(0, `TMA_SPR_MSR, 0, 32'h00000000);
        spr(0, `TMA_SPR_SRR, 0, 32'h00004010);
        tick;
        tick;
        if (exq.size() != 0)
            chk(32'h0, 32'h1);
        results;
    end
endmodule
bind tma_assist tma_chk chk_i (.mclk_i, .rstn_i, .lk_valid_i, .lk_kind_i, .exc_req_i, .rfi_i,
    .spr_rd_i, .spr_wr_i, .gpr_num_i, .hit_o, .miss_o, .vector_o, .spr_ack_o, .spr_err_o,
    .spr_rdata_o, .gpr_temp_o, .scratch_bank_o, .fetch_xlate_on_o, .data_xlate_on_o,
    .user_mode_o);
